// ===== tsc_chk.sv
// Port checker for the streaming control block.
// Assumes it is bound into tsc_streaming_control with one clock.
`timescale 1ns/1ps
module tsc_chk
  import tsc_pkg::*;
#(
  parameter int unsigned FIRST_BYTE_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic tape_run,
  input wire logic tape_fwd,
  input wire logic tape_high_speed,
  input wire logic long_gap_out,
  input wire logic first_byte
);
  localparam int FB_LO = FIRST_BYTE_CYC - 2;
  localparam int FB_HI = FIRST_BYTE_CYC + 3;
  logic cmd_ok;
  // Command accepted while the tape stands still
  assign cmd_ok = wr_stb && addr == REG_CMD && !wdata[6] && !tape_run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Assertions
  // ****************
  a_reset_values: assert property (disable iff (1'b0) rst |=> !tape_run && tape_fwd && !tape_high_speed
    && !long_gap_out && rdata == 16'h0000 && !first_byte) else $error("reset values wrong");
  a_rdata_quiet: assert property (!rd_stb |=> rdata == 16'h0000) else $error("rdata not zero");
  a_unmapped_zero: assert property (rd_stb && addr > REG_BLOCK |=> rdata == 16'h0000) else $error("unmapped read");
  a_fb_single: assert property (first_byte |=> !first_byte) else $error("first byte pulse too long");
  a_fb_moving: assert property (first_byte |-> tape_run) else $error("first byte with tape stopped");
  a_gap_long: assert property (cmd_ok && wdata[3:0] == CMD_LONG_GAP_SET |-> ##[1:3] long_gap_out)
    else $error("long gap not set");
  a_gap_short: assert property (cmd_ok && wdata[3:0] == CMD_LONG_GAP_RESET |-> ##[1:3] !long_gap_out)
    else $error("short gap not set");
  a_erase_fast: assert property (cmd_ok && wdata[3:0] == CMD_ERASE |-> ##[1:3] tape_high_speed)
    else $error("erase not at high speed");
  a_stream_sel: assert property (cmd_ok && wdata[3:0] == CMD_HIGH_SPEED |-> ##[1:3] tape_high_speed)
    else $error("streaming not selected");
  a_read_starts: assert property (cmd_ok && wdata[3:0] == CMD_READ |-> ##[1:3] tape_run)
    else $error("idle read did not start");
  a_access_time: assert property (cmd_ok && wdata[3:0] == CMD_READ |-> ##[FB_LO:FB_HI] first_byte)
    else $error("access time wrong");
  c_stream_xfer: cover property (tape_high_speed && first_byte);
  c_reverse: cover property (tape_run && !tape_fwd);
  c_long_gap: cover property (long_gap_out && first_byte);
endmodule

bind tsc_streaming_control tsc_chk #(.FIRST_BYTE_CYC(FIRST_BYTE_CYC)) u_tsc_chk (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tape_run(tape_run), .tape_fwd(tape_fwd),
  .tape_high_speed(tape_high_speed), .long_gap_out(long_gap_out), .first_byte(first_byte));

// ===== tsc_pkg.sv
// Package for the tape streaming control block: commands, states, counts.
// Assumes a 50 MHz clock; all times are converted to cycles here.
package tsc_pkg;

  localparam int unsigned CLK_HZ = 50000000;

  // Command codes on wdata[3:0] of REG_CMD
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_TMARK = 4'h3;
  localparam logic [3:0] CMD_FSB = 4'h4;
  localparam logic [3:0] CMD_BSB = 4'h5;
  localparam logic [3:0] CMD_LOW_SPEED = 4'h6;
  localparam logic [3:0] CMD_HIGH_SPEED = 4'h7;
  localparam logic [3:0] CMD_LONG_GAP_SET = 4'h8;
  localparam logic [3:0] CMD_LONG_GAP_RESET = 4'h9;
  localparam logic [3:0] CMD_SENSE = 4'hA;
  localparam logic [3:0] CMD_SENSE_ID = 4'hB;
  localparam logic [3:0] CMD_ERASE = 4'hC;

  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_SENSE_IDX = 4'h3;
  localparam logic [3:0] REG_SENSE_DATA = 4'h4;
  localparam logic [3:0] REG_MODEL = 4'h5;
  localparam logic [3:0] REG_CNT_SEL = 4'h6;
  localparam logic [3:0] REG_CNT_DATA = 4'h7;
  localparam logic [3:0] REG_BLOCK = 4'h8;

  // Control/status bit positions
  localparam int CTRL_DONE_BIT = 0;
  localparam int CTRL_CHAIN_BIT = 1;
  localparam int CTRL_DCHAIN_BIT = 2;
  localparam int ST_STREAM_BIT = 0;
  localparam int ST_LONG_GAP_BIT = 1;
  localparam int ST_MOVING_BIT = 2;
  localparam int ST_OVERRUN_BIT = 3;
  localparam int ST_UCHECK_BIT = 4;
  localparam int ST_OFLOW_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_TERM_BIT = 7;
  localparam int ST_FWD_BIT = 8;
  localparam int ST_HISPEED_BIT = 9;

  // Reset values
  localparam logic RST_LONG_GAP = 1'b0;
  localparam logic RST_STREAM = 1'b0;

  // Times in microseconds
  localparam int unsigned T_WIN_WR_SHORT_US = 2700;
  localparam int unsigned T_WIN_WR_LONG_US = 8700;
  localparam int unsigned T_WIN_RD_SHORT_US = 4200;
  localparam int unsigned T_WIN_RD_LONG_US = 8700;
  localparam int unsigned T_POSITION_US = 870000;
  localparam int unsigned T_FIRST_BYTE_US = 295000;

  // Derived cycle counts (windows are longest times, round down)
  localparam int unsigned CYC_WIN_WR_SHORT = T_WIN_WR_SHORT_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_WIN_WR_LONG = T_WIN_WR_LONG_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_WIN_RD_SHORT = T_WIN_RD_SHORT_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_WIN_RD_LONG = T_WIN_RD_LONG_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_POSITION = T_POSITION_US * (CLK_HZ / 1000000);
  localparam int unsigned CYC_FIRST_BYTE = T_FIRST_BYTE_US * (CLK_HZ / 1000000);

  // Sense layout
  localparam int SENSE_BYTES = 32;
  localparam int SENSE_STD_BYTES = 24;
  localparam int NUM_COUNTERS = 8;
  localparam int CNT_FETCH = 0;
  localparam int CNT_STORE = 1;
  localparam int CNT_ERR_MULTI = 2;
  localparam int CNT_ERR_SKEW = 3;
  localparam int CNT_ERR_DATA = 4;
  localparam int CNT_OVERRUN = 5;
  localparam int CNT_RETRY_RD = 6;
  localparam int CNT_RETRY_WR = 7;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;

  // Retry limits
  localparam logic [5:0] RETRY_RD_SS = 6'h05;
  localparam logic [5:0] RETRY_RD_STREAM = 6'h28;
  localparam logic [5:0] RETRY_WR = 6'h0F;

  typedef enum logic [2:0] {
    TSC_IDLE = 3'b000,
    TSC_XFER = 3'b001,
    TSC_GAP = 3'b010,
    TSC_POSITION = 3'b011,
    TSC_ACCESS = 3'b100
  } tsc_state_t;

endpackage

// ===== tsc_streaming_control.sv
// Tape streaming control: command sequencing, gap window, repositioning, sense.
// Assumes software drives the plain register port; the transport reports
// block completion and errors as asynchronous pins, synchronised here.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module tsc_streaming_control
  import tsc_pkg::*;
#(
  parameter int unsigned POSITION_CYC = CYC_POSITION,
  parameter int unsigned FIRST_BYTE_CYC = CYC_FIRST_BYTE,
  parameter logic [15:0] HOST_MODEL = 16'h1234 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic blk_done_pin,
  input wire logic err_pin,
  input wire logic [1:0] err_kind_pin,
  output logic tape_run,
  output logic tape_fwd,
  output logic tape_high_speed,
  output logic long_gap_out,
  output logic first_byte
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [1:0] done_s_r;
  logic [1:0] err_s_r;
  logic [1:0] kind0_s_r;
  logic [1:0] kind1_s_r;
  logic done_q_r;
  logic blk_done;
  logic err_ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      done_s_r <= 2'h0;
      err_s_r <= 2'h0;
      kind0_s_r <= 2'h0;
      kind1_s_r <= 2'h0;
      done_q_r <= 1'b0;
    end else begin
      done_s_r <= {done_s_r[0], blk_done_pin};
      err_s_r <= {err_s_r[0], err_pin};
      kind0_s_r <= {kind0_s_r[0], err_kind_pin[0]};
      kind1_s_r <= {kind1_s_r[0], err_kind_pin[1]};
      done_q_r <= done_s_r[1];
    end
  end

  assign blk_done = done_s_r[1] & ~done_q_r;
  assign err_ev = blk_done & err_s_r[1];

  function automatic logic is_stream_cmd(input logic [3:0] c);
    return (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_TMARK) ||
           (c == CMD_FSB) || (c == CMD_BSB);
  endfunction

  function automatic logic cmd_fwd(input logic [3:0] c);
    return c != CMD_BSB;
  endfunction

  // ****************************************************
  // Register port and command capture
  // ****************************************************
  tsc_state_t state_r;
  logic stream_r;
  logic long_gap_r;
  logic fwd_r;
  logic overrun_r;
  logic ucheck_r;
  logic oflow_r;
  logic term_r;
  logic pend_r;
  logic [3:0] pend_cmd_r;
  logic [3:0] last_cmd_r;
  logic [4:0] sense_idx_r;
  logic [2:0] cnt_sel_r;
  logic [15:0] cnt_r [NUM_COUNTERS];
  logic [15:0] block_r;
  logic [5:0] retry_r;
  logic [31:0] timer_r;
  logic cmd_wr;
  logic cmd_ok;
  logic sense_rd;
  logic [7:0] sense_byte;
  logic [15:0] rdata_nxt;

  assign cmd_wr = wr_stb && (addr == REG_CMD);
  // Data chaining is only legal on the two sense commands
  assign cmd_ok = cmd_wr && !(wdata[CTRL_DCHAIN_BIT + 4] &&
                  wdata[3:0] != CMD_SENSE && wdata[3:0] != CMD_SENSE_ID);
  assign sense_rd = rd_stb && (addr == REG_SENSE_DATA) && (sense_idx_r == 5'(SENSE_BYTES - 1));

  // Sense bytes: 0..23 standard layout, 24..31 drive specific
  always_comb begin
    sense_byte = 8'h00;
    if (sense_idx_r < 5'(SENSE_STD_BYTES)) begin
      unique case (sense_idx_r[1:0])
        2'h0: sense_byte = {ucheck_r, overrun_r, 6'h00};
        2'h1: sense_byte = {fwd_r, stream_r, long_gap_r, 5'h00};
        2'h2: sense_byte = cnt_r[sense_idx_r[4:2] & 3'h7][7:0];
        2'h3: sense_byte = cnt_r[sense_idx_r[4:2] & 3'h7][15:8];
      endcase
    end else begin
      unique case (sense_idx_r[2:0])
        3'h0: sense_byte = HOST_MODEL[15:8];
        3'h1: sense_byte = HOST_MODEL[7:0];
        3'h2: sense_byte = {oflow_r, 3'h0, last_cmd_r};
        3'h3: sense_byte = {2'h0, retry_r};
        3'h4: sense_byte = block_r[15:8];
        3'h5: sense_byte = block_r[7:0];
        default: sense_byte = 8'h00;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (addr)
      REG_STATUS: begin
        rdata_nxt[ST_STREAM_BIT] = stream_r;
        rdata_nxt[ST_LONG_GAP_BIT] = long_gap_r;
        rdata_nxt[ST_MOVING_BIT] = state_r != TSC_IDLE;
        rdata_nxt[ST_OVERRUN_BIT] = overrun_r;
        rdata_nxt[ST_UCHECK_BIT] = ucheck_r;
        rdata_nxt[ST_OFLOW_BIT] = oflow_r;
        rdata_nxt[ST_BUSY_BIT] = pend_r;
        rdata_nxt[ST_TERM_BIT] = term_r;
        rdata_nxt[ST_FWD_BIT] = fwd_r;
        rdata_nxt[ST_HISPEED_BIT] = tape_high_speed;
      end
      REG_CMD: rdata_nxt = {12'h000, last_cmd_r};
      REG_SENSE_IDX: rdata_nxt = {11'h000, sense_idx_r};
      REG_SENSE_DATA: rdata_nxt = {8'h00, sense_byte};
      REG_MODEL: rdata_nxt = HOST_MODEL;
      REG_CNT_SEL: rdata_nxt = {13'h0000, cnt_sel_r};
      REG_CNT_DATA: rdata_nxt = cnt_r[cnt_sel_r];
      REG_BLOCK: rdata_nxt = block_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd_stb) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sense_idx_r <= 5'h00;
      cnt_sel_r <= 3'h0;
    end else begin
      if (wr_stb && addr == REG_SENSE_IDX) begin
        sense_idx_r <= wdata[4:0];
      end else if (rd_stb && addr == REG_SENSE_DATA) begin
        sense_idx_r <= sense_idx_r + 5'h01;
      end
      if (wr_stb && addr == REG_CNT_SEL) begin
        cnt_sel_r <= wdata[2:0];
      end
    end
  end

  // ****************************************************
  // Mode settings
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      long_gap_r <= RST_LONG_GAP;
      stream_r <= RST_STREAM;
    end else if (cmd_ok && state_r == TSC_IDLE) begin
      unique case (wdata[3:0])
        CMD_LONG_GAP_SET: long_gap_r <= 1'b1;
        CMD_LONG_GAP_RESET: long_gap_r <= 1'b0;
        CMD_LOW_SPEED: stream_r <= 1'b0;
        CMD_HIGH_SPEED: stream_r <= 1'b1;
        default: stream_r <= stream_r;
      endcase
    end else if (cmd_ok && !is_stream_cmd(wdata[3:0]) && state_r == TSC_GAP) begin
      // Mode change while streaming takes effect; streaming is broken below
      unique case (wdata[3:0])
        CMD_LONG_GAP_SET: long_gap_r <= 1'b1;
        CMD_LONG_GAP_RESET: long_gap_r <= 1'b0;
        CMD_LOW_SPEED: stream_r <= 1'b0;
        CMD_HIGH_SPEED: stream_r <= 1'b1;
        default: stream_r <= stream_r;
      endcase
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  logic [31:0] win_cyc;
  logic win_end;

  // Window depends on gap size and the kind of the last command
  assign win_cyc = (last_cmd_r == CMD_READ) ? (long_gap_r ? CYC_WIN_RD_LONG : CYC_WIN_RD_SHORT)
                                            : (long_gap_r ? CYC_WIN_WR_LONG : CYC_WIN_WR_SHORT);
  assign win_end = timer_r >= win_cyc - 32'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= TSC_IDLE;
      fwd_r <= 1'b1;
      overrun_r <= 1'b0;
      term_r <= 1'b0;
      pend_r <= 1'b0;
      pend_cmd_r <= 4'h0;
      last_cmd_r <= 4'h0;
      timer_r <= 32'h0;
      first_byte <= 1'b0;
      retry_r <= 6'h00;
      block_r <= 16'h0000;
    end else begin
      first_byte <= 1'b0;
      if (cmd_wr && !cmd_ok) begin
        term_r <= 1'b1;
      end else if (cmd_ok) begin
        term_r <= 1'b0;
      end
      if (wr_stb && addr == REG_CTRL && wdata[CTRL_DONE_BIT]) begin
        overrun_r <= 1'b0;
      end
      unique case (state_r)
        TSC_IDLE: begin
          timer_r <= 32'h0;
          if (pend_r || (cmd_ok && is_stream_cmd(wdata[3:0]))) begin
            last_cmd_r <= pend_r ? pend_cmd_r : wdata[3:0];
            fwd_r <= cmd_fwd(pend_r ? pend_cmd_r : wdata[3:0]);
            pend_r <= 1'b0;
            state_r <= TSC_ACCESS;
          end else if (cmd_ok && wdata[3:0] == CMD_ERASE) begin
            last_cmd_r <= CMD_ERASE;
            fwd_r <= 1'b1;
            state_r <= TSC_XFER;
          end
        end
        TSC_ACCESS: begin
          // Reposition-to-data delay before the first byte moves
          if (timer_r >= FIRST_BYTE_CYC - 1) begin
            timer_r <= 32'h0;
            first_byte <= 1'b1;
            state_r <= TSC_XFER;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        TSC_XFER: begin
          timer_r <= 32'h0;
          if (blk_done) begin
            block_r <= fwd_r ? block_r + 16'h0001 : block_r - 16'h0001;
            if (err_ev && retry_r < ((last_cmd_r == CMD_READ) ?
                (stream_r ? RETRY_RD_STREAM : RETRY_RD_SS) : RETRY_WR)) begin
              retry_r <= retry_r + 6'h01;
              state_r <= TSC_ACCESS;
            end else if (stream_r && last_cmd_r != CMD_ERASE) begin
              retry_r <= 6'h00;
              state_r <= TSC_GAP;
            end else begin
              retry_r <= 6'h00;
              state_r <= TSC_IDLE;
            end
          end
        end
        TSC_GAP: begin
          timer_r <= timer_r + 32'h1;
          if (cmd_ok && is_stream_cmd(wdata[3:0]) && cmd_fwd(wdata[3:0]) == fwd_r && !win_end) begin
            last_cmd_r <= wdata[3:0];
            timer_r <= 32'h0;
            first_byte <= 1'b1;
            state_r <= TSC_XFER;
          end else if (win_end || (cmd_ok && !is_stream_cmd(wdata[3:0])) ||
                       (cmd_ok && cmd_fwd(wdata[3:0]) != fwd_r)) begin
            if (win_end) overrun_r <= 1'b1;
            if (cmd_ok && is_stream_cmd(wdata[3:0])) begin
              pend_r <= 1'b1;
              pend_cmd_r <= wdata[3:0];
            end
            timer_r <= 32'h0;
            state_r <= TSC_POSITION;
          end
        end
        TSC_POSITION: begin
          if (cmd_ok && is_stream_cmd(wdata[3:0])) begin
            pend_r <= 1'b1;
            pend_cmd_r <= wdata[3:0];
          end
          if (timer_r >= POSITION_CYC - 1) begin
            timer_r <= 32'h0;
            state_r <= TSC_IDLE;
          end else begin
            timer_r <= timer_r + 32'h1;
          end
        end
        default: state_r <= TSC_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Transport outputs
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      tape_run <= 1'b0;
      tape_fwd <= 1'b1;
      tape_high_speed <= 1'b0;
      long_gap_out <= 1'b0;
    end else begin
      tape_run <= state_r != TSC_IDLE;
      tape_fwd <= (state_r == TSC_POSITION) ? ~fwd_r : fwd_r;
      tape_high_speed <= stream_r || (state_r == TSC_XFER && last_cmd_r == CMD_ERASE);
      long_gap_out <= long_gap_r;
    end
  end

  // ****************************************************
  // Usage, error and retry counters
  // ****************************************************
  logic start_cmd;

  assign start_cmd = cmd_ok && is_stream_cmd(wdata[3:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        cnt_r[i] <= 16'h0000;
      end
      oflow_r <= 1'b0;
      ucheck_r <= 1'b0;
    end else begin
      if (sense_rd) begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
          cnt_r[i] <= 16'h0000;
        end
        oflow_r <= 1'b0;
        ucheck_r <= 1'b0;
      end else if (blk_done && state_r == TSC_XFER) begin
        // Usage and error counts skip retry passes; retry counts only then
        if (retry_r == 6'h00 && !err_ev) begin
          if (last_cmd_r == CMD_READ) cnt_r[CNT_FETCH] <= cnt_r[CNT_FETCH] + 16'h0001;
          if (last_cmd_r == CMD_WRITE) cnt_r[CNT_STORE] <= cnt_r[CNT_STORE] + 16'h0001;
        end
        if (err_ev && retry_r == 6'h00) begin
          unique case ({kind1_s_r[1], kind0_s_r[1]})
            2'h0: cnt_r[CNT_ERR_MULTI] <= cnt_r[CNT_ERR_MULTI] + 16'h0001;
            2'h1: cnt_r[CNT_ERR_SKEW] <= cnt_r[CNT_ERR_SKEW] + 16'h0001;
            2'h2: cnt_r[CNT_ERR_DATA] <= cnt_r[CNT_ERR_DATA] + 16'h0001;
            2'h3: cnt_r[CNT_OVERRUN] <= cnt_r[CNT_OVERRUN] + 16'h0001;
          endcase
        end
        if (retry_r != 6'h00) begin
          if (last_cmd_r == CMD_READ) cnt_r[CNT_RETRY_RD] <= cnt_r[CNT_RETRY_RD] + 16'h0001;
          else cnt_r[CNT_RETRY_WR] <= cnt_r[CNT_RETRY_WR] + 16'h0001;
        end
      end
      if (!sense_rd) begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
          if (cnt_r[i] == CNT_FULL - 16'h0001) oflow_r <= 1'b1;
        end
        if (oflow_r && start_cmd) ucheck_r <= 1'b1;
      end
    end
  end

endmodule

// ===== tsc_streaming_control_bench.sv
// Self-checking bench for the streaming control block.
// Assumes shortened positioning and access parameters.
`timescale 1ns/1ps
module tsc_streaming_control_bench;
  import tsc_pkg::*;
  localparam int POS = 200;
  localparam int FB = 50;
  localparam logic [15:0] MODEL = 16'h5A3C; // Arbitrary value
  logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, err_req = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v, w;
  logic blk_done_pin, err_pin, tape_run, tape_fwd, tape_high_speed, long_gap_out, first_byte;
  logic [1:0] err_kind_pin;
  int bad_count = 0;
  int total_checks = 0;
  int n, i;
  logic [5:0] rows [4] = '{{CMD_LONG_GAP_SET, 2'b10}, {CMD_HIGH_SPEED, 2'b11},
    {CMD_LONG_GAP_RESET, 2'b01}, {CMD_LOW_SPEED, 2'b00}};
  logic [3:0] seq [4] = '{CMD_WRITE, CMD_TMARK, CMD_FSB, CMD_READ};
  tsc_streaming_control #(.POSITION_CYC(POS), .FIRST_BYTE_CYC(FB), .HOST_MODEL(MODEL)) u_tsc_streaming_control (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .blk_done_pin(blk_done_pin), .err_pin(err_pin), .err_kind_pin(err_kind_pin), .tape_run(tape_run),
    .tape_fwd(tape_fwd), .tape_high_speed(tape_high_speed), .long_gap_out(long_gap_out), .first_byte(first_byte));
  tsc_transport_model #(.BLK_CYC(30)) u_tsc_transport_model (.clk(clk), .rst(rst), .first_byte(first_byte),
    .err_req(err_req), .blk_done_pin(blk_done_pin), .err_pin(err_pin), .err_kind_pin(err_kind_pin));
  initial begin
    forever #10 clk = ~clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_fb(input int lim, output int cnt);
    cnt = 0;
    #1;
    while (first_byte !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic blk_end;
    int k;
    k = 0;
    while (blk_done_pin !== 1'b1 && k < 500) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    do_reset();
    #1;
    check("tape_fwd", tape_fwd, 1'b1);
    check("long_gap_out", long_gap_out, 1'b0);
    rd(REG_STATUS, v);
    check("status", v[1:0], 2'b00);
    for (i = 0; i < 4; i++) begin
      wr(REG_CMD, {12'h000, rows[i][5:2]});
      repeat (3) @(posedge clk);
      rd(REG_STATUS, v);
      check("long_gap_out", long_gap_out, rows[i][1]);
      check("tape_high_speed", tape_high_speed, rows[i][0]);
      check("status_mode", {v[ST_LONG_GAP_BIT], v[ST_STREAM_BIT]}, rows[i][1:0]);
    end
    $display("mode table done");
    rd(4'hF, v);
    check("unmapped", v, 16'h0000);
    rd(REG_MODEL, v);
    check("model", v, MODEL);
    wr(REG_CMD, {12'h000, CMD_ERASE});
    repeat (3) @(posedge clk);
    #1;
    check("erase_speed", tape_high_speed, 1'b1);
    do_reset();
    wr(REG_CMD, {12'h004, CMD_READ});
    rd(REG_STATUS, v);
    check("chain_term", v[ST_TERM_BIT], 1'b1);
    do_reset();
    wr(REG_CMD, {12'h004, CMD_SENSE});
    rd(REG_STATUS, v);
    check("sense_chain", v[ST_TERM_BIT], 1'b0);
    $display("misc done");
    do_reset();
    for (i = 0; i < 2; i++) begin
      wr(REG_CMD, {12'h000, CMD_READ});
      wait_fb(100, n);
      check("access_time", n >= FB - 2 && n <= FB + 3, 1'b1);
      blk_end();
    end
    wr(REG_CNT_SEL, 16'(CNT_FETCH));
    rd(REG_CNT_DATA, v);
    check("fetch_count", v, 16'h0002);
    wr(REG_CNT_SEL, 16'(CNT_STORE));
    rd(REG_CNT_DATA, v);
    check("store_count", v, 16'h0000);
    wr(REG_SENSE_IDX, 16'h0000);
    for (i = 0; i < 32; i++) begin
      rd(REG_SENSE_DATA, v);
      if (i == 2) check("sense_fetch", v, 16'h0002);
      if (i == 24) check("sense_model", v, {8'h00, MODEL[15:8]});
    end
    rd(REG_SENSE_IDX, v);
    check("sense_len", v[4:0], 5'h00);
    wr(REG_CNT_SEL, 16'(CNT_FETCH));
    rd(REG_CNT_DATA, v);
    check("count_clear", v, 16'h0000);
    @(posedge clk);
    err_req <= 1'b1;
    wr(REG_CMD, {12'h000, CMD_READ});
    wait_fb(100, n);
    blk_end();
    err_req <= 1'b0;
    wait_fb(100, n);
    check("retry_access", first_byte, 1'b1);
    blk_end();
    wr(REG_CNT_SEL, 16'(CNT_ERR_DATA));
    rd(REG_CNT_DATA, v);
    check("err_count", v, 16'h0001);
    wr(REG_CNT_SEL, 16'(CNT_RETRY_RD));
    rd(REG_CNT_DATA, v);
    check("retry_count", v, 16'h0001);
    rd(REG_BLOCK, v);
    for (i = 0; i < 3; i++) begin
      wr(REG_CMD, {12'h000, (i == 1) ? CMD_READ : CMD_BSB});
      wait_fb(100, n);
      check("emul_dir", tape_fwd, i == 1);
      blk_end();
    end
    rd(REG_BLOCK, w);
    check("emul_block", w, 16'(v - 16'h0001));
    $display("counters done");
    do_reset();
    wr(REG_CMD, {12'h000, CMD_HIGH_SPEED});
    repeat (3) @(posedge clk);
    wr(REG_CMD, {12'h000, CMD_READ});
    wait_fb(100, n);
    for (i = 0; i < 4; i++) begin
      blk_end();
      check("run_in_gap", tape_run, 1'b1);
      wr(REG_CMD, {12'h000, seq[i]});
      wait_fb(5, n);
      check("no_stop", n <= 3, 1'b1);
    end
    rd(REG_STATUS, v);
    check("no_overrun", v[ST_OVERRUN_BIT], 1'b0);
    blk_end();
    wr(REG_CMD, {12'h000, CMD_LONG_GAP_SET});
    repeat (5) @(posedge clk);
    #1;
    check("reverse", tape_fwd, 1'b0);
    wr(REG_CMD, {12'h000, CMD_READ});
    wait_fb(400, n);
    check("reposition", n + 7 >= POS + FB - 4 && n + 7 <= POS + FB + 6, 1'b1);
    check("long_gap_out", long_gap_out, 1'b1);
    blk_end();
    wr(REG_CMD, {12'h000, CMD_BSB});
    repeat (3) @(posedge clk);
    #1;
    check("dir_change", first_byte, 1'b0);
    $display("streaming done");
    tally_and_finish();
  end
endmodule

// ===== tsc_transport_model.sv
// Transport model: ends a block a fixed time after its first byte.
// Assumes the block's first_byte pulse marks the start of each block.
`timescale 1ns/1ps
module tsc_transport_model #(
  parameter int BLK_CYC = 30
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic first_byte,
  input wire logic err_req,
  output logic blk_done_pin,
  output logic err_pin,
  output logic [1:0] err_kind_pin
);
  int cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
    end else if (first_byte) begin
      cnt <= BLK_CYC + 4;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // Done level held four cycles so the block's synchroniser sees it
  always_ff @(posedge clk) begin
    blk_done_pin <= !rst && cnt != 0 && cnt <= 4;
    err_pin <= err_req;
    err_kind_pin <= 2'h2;
  end
endmodule
